// ==== logic/key_port_consts.svh ====
`ifndef KEY_PORT_CONSTS_SVH
`define KEY_PORT_CONSTS_SVH

// register addresses on the plain register port
`define KP_ADDR_SELECT   16'hff20
`define KP_ADDR_DATA     16'hff21
`define KP_ADDR_COMPARE  16'hff22
`define KP_ADDR_MASK     16'hffe4
`define KP_ADDR_FACTOR   16'hfff4
`define KP_ADDR_SLEEP    16'hfff8

// field positions
`define KP_MASK_BIT      0
`define KP_FACTOR_BIT    0
`define KP_SLEEP_BIT     0
`define KP_WAKE_BIT      1

// reset values
`define KP_RST_SELECT    4'h0
`define KP_RST_COMPARE   4'hf
`define KP_RST_MASK      1'h0
`define KP_RST_FACTOR    1'h0

`endif

// ==== logic/key_port_pkg.sv ====
`default_nettype none

package key_port_pkg;

    // power state of the core as seen by the wake-up logic
    typedef enum logic {
        run_state,
        asleep_state
    } power_state_type;

    typedef logic [15:0] reg_addr_type;
    typedef logic [3:0]  reg_data_type;

endpackage : key_port_pkg

`default_nettype wire

// ==== logic/key_detect_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface key_detect_if #(
    parameter int PINS = 4
);
    logic [PINS-1:0] pins_sync;      // synchronised pin levels
    logic [PINS-1:0] select;         // per-pin interrupt select
    logic [PINS-1:0] compare;        // per-pin compare level
    logic            mismatch_event; // one-cycle match to mismatch pulse

    modport detector (
        output pins_sync,
        input  select,
        input  compare,
        output mismatch_event
    );

    modport control (
        input  pins_sync,
        output select,
        output compare,
        input  mismatch_event
    );
endinterface : key_detect_if

`default_nettype wire

// ==== logic/key_match_detect.sv ====
`timescale 1ns/1ps
`default_nettype none

module key_match_detect #(
    parameter int PINS = 4
) (
    input  wire logic            core_clk,   // system clock
    input  wire logic            rst,        // async reset, active high
    input  wire logic [PINS-1:0] pins_async, // raw key input pins
    key_detect_if.detector       det         // towards the register side
);
    logic [PINS-1:0] sync_first;
    logic [PINS-1:0] sync_second;
    logic [PINS-1:0] bit_ok;
    logic            all_match;
    logic            prev_match;
    logic            event_q;

    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync_first  <= '0;
            sync_second <= '0;
        end else begin
            sync_first  <= pins_async;
            sync_second <= sync_first;
        end
    end

    // per pin: unselected pins always count as matching
    for (genvar i = 0; i < PINS; i++) begin : g_bit
        assign bit_ok[i] = ~det.select[i] | (sync_second[i] == det.compare[i]);
    end

    // compare 1 waits for a fall, 0 for a rise: leaving the level is the edge
    assign all_match = &bit_ok;

    // only a full match going to mismatch fires; mismatch to mismatch is quiet
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_match <= 1'h1;
            event_q    <= 1'h0;
        end else begin
            prev_match <= all_match;
            event_q    <= prev_match & ~all_match;
        end
    end

    assign det.pins_sync      = sync_second;
    assign det.mismatch_event = event_q;
endmodule : key_match_detect

`default_nettype wire

// ==== logic/key_input_port.sv ====
// How it works
// - four input pins, each able to join the shared key interrupt.
// - per-pin select bit; unselected pins never influence the interrupt.
// - per-pin compare bit chooses rising or falling edge.
// - interrupt fires when selected pins go from full match to mismatch.
// - a change between two mismatch states raises nothing.
// - one shared mask bit gates the interrupt for all four pins.
// - the event sets the shared factor flag to one.
// - a key interrupt wakes the device from sleep.
// - compare 1 means falling, 0 rising; all reset to ones.
// - flag sets even when masked; masked interrupt never reaches the cpu.
// - writing one clears the flag, zero does nothing; a new event in the same cycle wins over the clear.
// - data reads give pin levels; writes to data are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "key_port_consts.svh"

module key_input_port
    import key_port_pkg::*;
#(
    parameter int PINS = 4
) (
    input  wire logic            core_clk,          // system clock, 25 MHz
    input  wire logic            rst,               // async reset, active high
    input  wire logic [PINS-1:0] key_input_pins,    // external key pins
    input  wire logic            sleep_instruction, // pulse: core enters sleep
    input  wire logic [15:0]     reg_addr,          // register address
    input  wire logic [3:0]      reg_wdata,         // register write data
    input  wire logic            reg_write,         // write strobe
    input  wire logic            reg_read,          // read strobe
    output var  logic [3:0]      reg_rdata,         // read data, cycle after read
    output var  logic            key_irq,           // level interrupt to cpu
    output var  logic            sleeping,          // high while asleep
    output var  logic            wake_pulse         // one-cycle wake-up pulse
);
    key_detect_if #(.PINS(PINS)) det_bus ();

    logic [PINS-1:0] irq_pin_select_bits;
    logic [PINS-1:0] edge_compare_bits;
    logic            key_irq_mask_bit;
    logic            key_irq_factor_flag;
    logic            wake_seen;
    power_state_type power_state;
    logic            next_factor;
    logic            key_event;
    logic            wr_select;
    logic            wr_compare;
    logic            wr_mask;
    logic            wr_factor;
    logic            wr_sleep;
    logic [3:0]      next_rdata;

    key_match_detect #(.PINS(PINS)) u_detect (
        .core_clk   (core_clk),
        .rst        (rst),
        .pins_async (key_input_pins),
        .det        (det_bus.detector)
    );

    assign det_bus.select  = irq_pin_select_bits;
    assign det_bus.compare = edge_compare_bits;
    assign key_event       = det_bus.mismatch_event;

    // write decode; the data address has no write term at all
    assign wr_select  = reg_write && (reg_addr == `KP_ADDR_SELECT);
    assign wr_compare = reg_write && (reg_addr == `KP_ADDR_COMPARE);
    assign wr_mask    = reg_write && (reg_addr == `KP_ADDR_MASK);
    assign wr_factor  = reg_write && (reg_addr == `KP_ADDR_FACTOR);
    assign wr_sleep   = reg_write && (reg_addr == `KP_ADDR_SLEEP);

    // select register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_pin_select_bits <= `KP_RST_SELECT;
        end else if (wr_select) begin
            irq_pin_select_bits <= reg_wdata[PINS-1:0];
        end
    end

    // compare register, ones at reset so idle-high keys wait for a press
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            edge_compare_bits <= `KP_RST_COMPARE;
        end else if (wr_compare) begin
            edge_compare_bits <= reg_wdata[PINS-1:0];
        end
    end

    // shared mask bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            key_irq_mask_bit <= `KP_RST_MASK;
        end else if (wr_mask) begin
            key_irq_mask_bit <= reg_wdata[`KP_MASK_BIT];
        end
    end

    // factor flag: set wins over a write-one clear so no event is lost
    always_comb begin
        next_factor = key_irq_factor_flag;
        if (wr_factor && reg_wdata[`KP_FACTOR_BIT]) begin
            next_factor = 1'h0;
        end
        if (key_event) begin
            next_factor = 1'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            key_irq_factor_flag <= `KP_RST_FACTOR;
        end else begin
            key_irq_factor_flag <= next_factor;
        end
    end

    // interrupt follows the next flag value so it lines up with the flag
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            key_irq <= 1'h0;
        end else begin
            key_irq <= next_factor & key_irq_mask_bit;
        end
    end

    // sleep tracking; waking needs the mask open, as software must ensure
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            power_state <= run_state;
            sleeping    <= 1'h0;
            wake_pulse  <= 1'h0;
        end else begin
            wake_pulse <= 1'h0;
            case (power_state)
                run_state: begin
                    if (sleep_instruction) begin
                        power_state <= asleep_state;
                        sleeping    <= 1'h1;
                    end
                end
                asleep_state: begin
                    if (key_event && key_irq_mask_bit) begin
                        power_state <= run_state;
                        sleeping    <= 1'h0;
                        wake_pulse  <= 1'h1;
                    end
                end
                default: begin
                    power_state <= run_state;
                    sleeping    <= 1'h0;
                end
            endcase
        end
    end

    // sticky record of the last wake-up, cleared by writing one
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wake_seen <= 1'h0;
        end else if (power_state == asleep_state && key_event && key_irq_mask_bit) begin
            wake_seen <= 1'h1;
        end else if (wr_sleep && reg_wdata[`KP_WAKE_BIT]) begin
            wake_seen <= 1'h0;
        end
    end

    // read mux; unused bits and unmapped addresses read zero
    always_comb begin
        next_rdata = 4'h0;
        case (reg_addr)
            `KP_ADDR_SELECT:  next_rdata[PINS-1:0] = irq_pin_select_bits;
            `KP_ADDR_DATA:    next_rdata[PINS-1:0] = det_bus.pins_sync;
            `KP_ADDR_COMPARE: next_rdata[PINS-1:0] = edge_compare_bits;
            `KP_ADDR_MASK:    next_rdata[`KP_MASK_BIT] = key_irq_mask_bit;
            `KP_ADDR_FACTOR:  next_rdata[`KP_FACTOR_BIT] = key_irq_factor_flag;
            `KP_ADDR_SLEEP: begin
                next_rdata[`KP_SLEEP_BIT] = sleeping;
                next_rdata[`KP_WAKE_BIT]  = wake_seen;
            end
            default:          next_rdata = 4'h0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 4'h0;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 4'h0;
        end
    end
endmodule : key_input_port

`default_nettype wire

// ==== verif/key_port_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "key_port_consts.svh"
module key_port_sva #(
    parameter int PINS = 4
) (
    input wire logic            core_clk,          // clock
    input wire logic            rst,               // reset
    input wire logic [PINS-1:0] key_input_pins,    // pins
    input wire logic            sleep_instruction, // sleep
    input wire logic [15:0]     reg_addr,          // address
    input wire logic [3:0]      reg_wdata,         // wdata
    input wire logic            reg_write,         // write
    input wire logic            reg_read,          // read
    input wire logic [3:0]      reg_rdata,         // rdata
    input wire logic            key_irq,           // irq
    input wire logic            sleeping,          // asleep
    input wire logic            wake_pulse         // wake
);
    logic mask_q;
    logic cmp_wr;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // shadow mask so irq can be tied to its cause
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mask_q <= 1'h0;
            cmp_wr <= 1'h0;
        end else if (reg_write) begin
            if (reg_addr == `KP_ADDR_MASK) mask_q <= reg_wdata[0];
            if (reg_addr == `KP_ADDR_COMPARE) cmp_wr <= 1'h1;
        end
    end
    AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 4'h0)
        else $error("rdata not idle");
    AST_UNUSED_BITS: assert property (
        reg_read && (reg_addr == `KP_ADDR_MASK || reg_addr == `KP_ADDR_FACTOR)
        |=> reg_rdata[3:1] == 3'h0) else $error("unused bits set");
    AST_CMP_RESET: assert property (
        reg_read && reg_addr == `KP_ADDR_COMPARE && !cmp_wr |=> reg_rdata == 4'hf)
        else $error("compare reset value");
    AST_MASK_OFF: assert property (
        reg_write && reg_addr == `KP_ADDR_MASK && !reg_wdata[0] ##1
        !(reg_write && reg_addr == `KP_ADDR_MASK) |=> !key_irq)
        else $error("irq while masked");
    AST_IRQ_MASK: assert property (key_irq |-> mask_q || $past(mask_q))
        else $error("irq without mask");
    AST_ZERO_NO_CLEAR: assert property (
        key_irq && !$past(reg_write) && !$past(reg_write, 2) && reg_write
        && reg_addr == `KP_ADDR_FACTOR && !reg_wdata[0] |=> key_irq)
        else $error("zero write cleared");
    AST_SLEEP_ENTER: assert property (sleep_instruction |=> sleeping || wake_pulse)
        else $error("no sleep");
    AST_WAKE_FALL: assert property (
        $fell(sleeping) |-> $past(wake_pulse) or ##[0:1] wake_pulse)
        else $error("sleep left silently");
    // main scenarios reached
    cover property ($rose(key_irq));
    cover property (wake_pulse);
    cover property (reg_read && reg_addr == `KP_ADDR_DATA);
endmodule : key_port_sva
bind key_input_port key_port_sva #(.PINS(PINS)) u_sva (
    .core_clk(core_clk), .rst(rst), .key_input_pins(key_input_pins),
    .sleep_instruction(sleep_instruction), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .key_irq(key_irq), .sleeping(sleeping),
    .wake_pulse(wake_pulse));
`default_nettype wire

// ==== verif/key_switch_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module key_switch_model (
    input  wire logic       core_clk, // system clock
    input  wire logic [3:0] level,    // wanted switch levels
    output var  logic [3:0] key_pins  // pin levels
);
    // pins move by nonblocking update on the rising edge; the design syncs them
    initial key_pins = 4'hf;
    always @(posedge core_clk) key_pins <= level;
endmodule : key_switch_model
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "key_port_consts.svh"
module tb_top import key_port_pkg::*;;
    logic core_clk, rst, sleep_instruction, reg_write, reg_read;
    logic key_irq, sleeping, wake_pulse;
    logic [3:0] level, pins, reg_wdata, reg_rdata;
    logic [15:0] reg_addr;
    int n_errors, total_checks;
    key_switch_model i_key_switch_model (
        .core_clk(core_clk), .level(level), .key_pins(pins));
    key_input_port #(.PINS(4)) i_key_input_port (
        .core_clk(core_clk), .rst(rst), .key_input_pins(pins),
        .sleep_instruction(sleep_instruction), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .key_irq(key_irq), .sleeping(sleeping),
        .wake_pulse(wake_pulse));
    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input reg_addr_type a, input reg_data_type d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge core_clk);
        reg_write <= 1'h0;
    endtask : wr
    task automatic rd(input reg_addr_type a, input reg_data_type e, input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge core_clk);
        reg_read <= 1'h0;
        @(negedge core_clk);
        check(what, reg_rdata, e);
    endtask : rd
    // pin to flag takes five edges; eight leaves margin
    task automatic settle();
        repeat (8) @(posedge core_clk);
    endtask : settle
    task automatic t_reset();
        rd(`KP_ADDR_SELECT, 4'h0, "select");
        rd(`KP_ADDR_COMPARE, 4'hf, "compare");
        rd(`KP_ADDR_MASK, 4'h0, "mask");
        rd(`KP_ADDR_FACTOR, 4'h0, "flag");
        wr(`KP_ADDR_DATA, 4'h0);
        rd(`KP_ADDR_DATA, 4'hf, "pins");
        rd(16'hff30, 4'h0, "unmapped");
    endtask : t_reset
    task automatic t_fall();
        wr(`KP_ADDR_SELECT, 4'h1);
        wr(`KP_ADDR_MASK, 4'h1);
        level <= 4'he;
        settle();
        check("irq", key_irq, 1'h1);
        rd(`KP_ADDR_FACTOR, 4'h1, "flag set");
        wr(`KP_ADDR_FACTOR, 4'h0);
        rd(`KP_ADDR_FACTOR, 4'h1, "flag kept");
        wr(`KP_ADDR_FACTOR, 4'h1);
        rd(`KP_ADDR_FACTOR, 4'h0, "flag clear");
        check("irq off", key_irq, 1'h0);
    endtask : t_fall
    // mismatch to mismatch, then an unselected pin
    task automatic t_mismatch();
        wr(`KP_ADDR_SELECT, 4'h3);
        level <= 4'hc;
        settle();
        rd(`KP_ADDR_FACTOR, 4'h0, "no event");
        level <= 4'h7;
        settle();
        rd(`KP_ADDR_FACTOR, 4'h0, "unselected");
        rd(`KP_ADDR_DATA, 4'h7, "levels");
    endtask : t_mismatch
    // rising edge on pin2 while masked
    task automatic t_rise();
        level <= 4'hb;
        wr(`KP_ADDR_COMPARE, 4'hb);
        wr(`KP_ADDR_SELECT, 4'h4);
        wr(`KP_ADDR_MASK, 4'h0);
        settle();
        level <= 4'hf;
        settle();
        rd(`KP_ADDR_FACTOR, 4'h1, "rise flag");
        check("masked irq", key_irq, 1'h0);
        wr(`KP_ADDR_FACTOR, 4'h1);
    endtask : t_rise
    task automatic t_sleep();
        wr(`KP_ADDR_MASK, 4'h1);
        level <= 4'hb;
        settle();
        sleep_instruction <= 1'h1;
        @(posedge core_clk);
        sleep_instruction <= 1'h0;
        @(negedge core_clk);
        check("asleep", sleeping, 1'h1);
        level <= 4'hf;
        for (int i = 0; i < 20 && wake_pulse !== 1'h1; i++) @(negedge core_clk);
        check("woken", wake_pulse, 1'h1);
        @(negedge core_clk);
        check("awake", sleeping, 1'h0);
        check("wake irq", key_irq, 1'h1);
        rd(`KP_ADDR_SLEEP, 4'h2, "wake seen");
        wr(`KP_ADDR_SLEEP, 4'h2);
        rd(`KP_ADDR_SLEEP, 4'h0, "wake clear");
    endtask : t_sleep
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        {rst, level, sleep_instruction, reg_addr} = {1'h1, 4'hf, 1'h0, 16'h0};
        {reg_wdata, reg_write, reg_read} = 6'h0;
        repeat (20) @(posedge core_clk);
        rst <= 1'h0;
        t_reset();
        t_fall();
        t_mismatch();
        t_rise();
        t_sleep();
        test_done();
    end
    // watchdog well beyond the roughly 130 cycles needed
    initial begin
        #200us;
        n_errors++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
